// ==== evl_defines.svh ====
// Purpose: Named constants of the event log mission control block.
// Assumes: Byte wide register port from a serial slave protocol engine.
// Notes: Offsets, bit positions, reset values and codes live here only.
`ifndef EVL_DEFINES_SVH
`define EVL_DEFINES_SVH

// Register offsets on the byte register port.
`define EVL_CTRL_ADDR 8'h0e
`define EVL_STAT_ADDR 8'h0f
`define EVL_ALARM_FIRST 8'h08
`define EVL_ALARM_LAST 8'h0b

// Control register bit positions.
`define EVL_CTRL_ARM_BIT 7
`define EVL_CTRL_WIPE_ARM_BIT 6
`define EVL_CTRL_DIS_HI_BIT 5
`define EVL_CTRL_DIS_LO_BIT 4
`define EVL_CTRL_WRAP_BIT 3
`define EVL_CTRL_EDGE_HI_BIT 2
`define EVL_CTRL_EDGE_LO_BIT 1
`define EVL_CTRL_OSC_BIT 0

// Status register bit positions; bits 7, 4 and 1 read as zero.
`define EVL_STAT_CLEARED_BIT 6
`define EVL_STAT_ACTIVE_BIT 5
`define EVL_STAT_WIPE_BIT 4
`define EVL_STAT_BATT_BIT 3
`define EVL_STAT_WRAP_BIT 2
`define EVL_STAT_ALARM_BIT 0

// Reset values: oscillator running, everything else off.
`define EVL_CTRL_RST 8'h01
`define EVL_CLEARED_RST 1'b0

// Interval select codes.
`define EVL_DIS_ALARM 2'b00
`define EVL_DIS_SEC 2'b01
`define EVL_DIS_MIN 2'b10
`define EVL_DIS_HOUR 2'b11

// Edge select code that is illegal.
`define EVL_EDGE_NONE 2'b00

// Log geometry and elapsed-time counter limits.
`define EVL_LOG_WORDS 1024
`define EVL_ETC_MAX 16'hffff
`define EVL_ETC_ZERO 16'h0000

`endif

// ==== evl_host_model.sv ====
// Purpose: Host model that drives the byte register port of the block.
// Assumes: Requests launch 1 ns after a rising clk edge and hold a cycle.
// Notes: The quiet time after a wipe is a parameter so runs stay short.
`timescale 1ns/10ps
`include "evl_defines.svh"
module evl_host_model #(
	parameter int QUIET_CYC = 12500
) (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr_stb,
	output logic reg_rd_stb,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// The port starts idle with no strobe raised.
	initial begin
		reg_wr_stb = 1'b0;
		reg_rd_stb = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// One write; address and data are inverted once released.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr_stb = 1'b1;
		@(posedge clk);
		#1;
		reg_wr_stb = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
		// A wipe request is followed by quiet time before any access.
		if (a == `EVL_STAT_ADDR && v[`EVL_STAT_WIPE_BIT]) begin
			repeat (QUIET_CYC) @(posedge clk);
		end
	endtask : wr

	// One read; the answer is registered a cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd_stb = 1'b1;
		@(posedge clk);
		#1;
		reg_rd_stb = 1'b0;
		reg_addr = ~a;
		@(posedge clk);
		#1;
		v = reg_rdata;
	endtask : rd
endmodule : evl_host_model

// ==== evl_mission.sv ====
// Purpose: Mission control and status of a battery-backed event recorder.
// Assumes: A protocol engine gives byte writes and reads; calendar ticks
//	and the alarm match arrive as one-cycle pulses on clk.
// Notes: Log storage, stamps and event counter sit outside; this block
//	issues their write and clear strobes.
`timescale 1ns/10ps
`include "evl_defines.svh"

module evl_mission #(
	parameter int LOG_WORDS = `EVL_LOG_WORDS,
	parameter int PTR_W = $clog2(LOG_WORDS) + 1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic reg_wr_stb,
	input wire logic reg_rd_stb,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sec_tick,
	input wire logic min_tick,
	input wire logic hour_tick,
	input wire logic alarm_match,
	input wire logic battery_low_pin,
	input wire logic event_pin_i,
	output logic event_pin_o,
	output logic event_pin_oe,
	output logic osc_run,
	output logic log_wr_stb,
	output logic [PTR_W-1:0] log_addr,
	output logic [15:0] log_data,
	output logic start_stamp_stb,
	output logic roll_stamp_wr,
	output logic [15:0] roll_stamp_data,
	output logic event_count_inc,
	output logic wipe_stb
);
	import evl_pkg::*;

	evl_sync_if pin_sync (); // Event pin, synchronised.
	evl_sync_if batt_sync (); // Battery pin, synchronised.

	evl_mission_t state_ff, nxt_state; // Mission state.
	logic [1:0] dis_ff, nxt_dis; // Interval select field.
	logic [1:0] edge_ff, nxt_edge; // Edge select field.
	logic wrap_en_ff, nxt_wrap_en; // Wrap enable.
	logic osc_ff, nxt_osc; // Oscillator enable.
	logic wipe_arm_ff, nxt_wipe_arm; // First half of the two-step wipe.
	logic cleared_ff, nxt_cleared; // Log cleared flag.
	logic wrap_flag_ff, nxt_wrap_flag; // Sticky wrap flag.
	logic alarm_ff, nxt_alarm; // Sticky alarm flag.
	logic [15:0] etc_ff, nxt_etc; // Elapsed-time counter.
	logic [PTR_W-1:0] ptr_ff, nxt_ptr; // Next log word to write.
	logic [7:0] rdata_ff, nxt_rdata; // Last read answer, held.
	logic oe_ff, nxt_oe; // Pin pull-down enable.
	logic log_wr_ff, nxt_log_wr; // Log write pulse.
	logic [PTR_W-1:0] log_addr_ff, nxt_log_addr; // Log byte address.
	logic [15:0] log_data_ff, nxt_log_data; // Log entry value.
	logic start_ff, nxt_start; // Start stamp capture pulse.
	logic roll_wr_ff, nxt_roll_wr; // Rollover stamp write pulse.
	logic [15:0] roll_data_ff, nxt_roll_data; // Rollover stamp value.
	logic evcnt_ff, nxt_evcnt; // Event counter step pulse.
	logic wipe_ff, nxt_wipe; // Store wipe pulse.

	logic evt; // Qualifying edge on the event pin.
	logic tick; // Selected calendar tick.
	logic guards_ok; // Settings allow a mission to start.
	logic log_full; // Every log word has been written.
	logic alarm_access; // Host touches an alarm register.
	logic log_req; // A log entry is due this cycle.
	logic log_is_evt; // The due entry closes a real event.
	logic [15:0] log_val; // Value of the due entry.

	evl_sync_edge u_pin_sync (
		.clk(clk),
		.srst(srst),
		.pin(event_pin_i),
		.sync(pin_sync)
	);

	evl_sync_edge u_batt_sync (
		.clk(clk),
		.srst(srst),
		.pin(battery_low_pin),
		.sync(batt_sync)
	);

	// Edge qualification and tick selection from the stored settings.
	always_comb begin
		evt = (edge_ff[0] & pin_sync.fall) |
			(edge_ff[1] & pin_sync.rise);
		case (dis_ff)
			`EVL_DIS_SEC: tick = sec_tick;
			`EVL_DIS_MIN: tick = min_tick;
			`EVL_DIS_HOUR: tick = hour_tick;
			default: tick = 1'b0;
		endcase
		guards_ok = (edge_ff != `EVL_EDGE_NONE) &&
			(dis_ff != `EVL_DIS_ALARM) && osc_ff;
		log_full = (ptr_ff == PTR_W'(LOG_WORDS));
		alarm_access = (reg_wr_stb | reg_rd_stb) &&
			(reg_addr >= `EVL_ALARM_FIRST) &&
			(reg_addr <= `EVL_ALARM_LAST);
	end

	// Mission, register and log sequencing. Host writes are handled
	// first, one per cycle in arrival order; a running mission that
	// survives the write still sees this cycle's pin edge, so no event
	// is lost to a concurrent register access.
	always_comb begin
		nxt_state = state_ff;
		nxt_dis = dis_ff;
		nxt_edge = edge_ff;
		nxt_wrap_en = wrap_en_ff;
		nxt_osc = osc_ff;
		nxt_wipe_arm = wipe_arm_ff;
		nxt_cleared = cleared_ff;
		nxt_wrap_flag = wrap_flag_ff;
		nxt_etc = etc_ff;
		nxt_ptr = ptr_ff;
		nxt_log_wr = 1'b0;
		nxt_log_addr = log_addr_ff;
		nxt_log_data = log_data_ff;
		nxt_start = 1'b0;
		nxt_roll_wr = 1'b0;
		nxt_roll_data = roll_data_ff;
		nxt_evcnt = 1'b0;
		nxt_wipe = 1'b0;
		log_req = 1'b0;
		log_is_evt = 1'b0;
		log_val = `EVL_ETC_ZERO;
		// Set beats the clear when both land together.
		nxt_alarm = (alarm_ff & ~alarm_access) | alarm_match;
		if (reg_wr_stb) begin
			// Any write other than a control write with bit 6 set drops the wipe arm.
			nxt_wipe_arm = 1'b0;
			if (reg_addr == `EVL_CTRL_ADDR) begin
				nxt_dis = reg_wdata[`EVL_CTRL_DIS_HI_BIT:`EVL_CTRL_DIS_LO_BIT];
				nxt_edge = reg_wdata[`EVL_CTRL_EDGE_HI_BIT:`EVL_CTRL_EDGE_LO_BIT];
				nxt_wrap_en = reg_wdata[`EVL_CTRL_WRAP_BIT];
				nxt_osc = reg_wdata[`EVL_CTRL_OSC_BIT];
				nxt_wipe_arm = reg_wdata[`EVL_CTRL_WIPE_ARM_BIT];
				if (state_ff == ms_run) begin
					nxt_state = ms_idle;
				end else if (reg_wdata[`EVL_CTRL_ARM_BIT] && cleared_ff) begin
					nxt_state = ms_armed; // Arm only a cleared log.
				end else begin
					nxt_state = ms_idle;
				end
			end else if (reg_addr == `EVL_STAT_ADDR) begin
				if (reg_wdata[`EVL_STAT_WIPE_BIT] && wipe_arm_ff &&
					osc_ff) begin
					// Wipe: stop, zero the store, raise the cleared flag.
					nxt_state = ms_idle;
					nxt_wipe = 1'b1;
					nxt_cleared = 1'b1;
					nxt_wrap_flag = 1'b0;
					nxt_ptr = '0;
				end else if (reg_wdata[`EVL_STAT_ACTIVE_BIT]) begin
					// A start over a running mission is left alone.
					if (state_ff != ms_run && cleared_ff &&
						guards_ok) begin
						nxt_state = ms_run;
						nxt_cleared = 1'b0;
						nxt_start = 1'b1;
						nxt_roll_wr = 1'b1;
						nxt_roll_data = `EVL_ETC_ZERO;
						nxt_evcnt = 1'b1;
						nxt_etc = `EVL_ETC_ZERO;
					end
				end else begin
					nxt_state = ms_idle;
				end
			end else if (state_ff == ms_run) begin
				// Writing any other location ends the mission.
				nxt_state = ms_idle;
			end
		end
		if (state_ff == ms_armed && nxt_state == ms_armed && evt &&
			guards_ok) begin
			// First qualifying edge starts the mission.
			nxt_state = ms_run;
			nxt_cleared = 1'b0;
			nxt_start = 1'b1;
			nxt_roll_wr = 1'b1;
			nxt_roll_data = `EVL_ETC_ZERO;
			nxt_evcnt = 1'b1;
			nxt_etc = `EVL_ETC_ZERO;
		end else if (state_ff == ms_run && nxt_state == ms_run) begin
			if (evt) begin
				// Zero is logged when no step has happened yet.
				log_req = 1'b1;
				log_is_evt = 1'b1;
				log_val = etc_ff;
				nxt_evcnt = 1'b1;
				nxt_etc = `EVL_ETC_ZERO;
			end else if (etc_ff == `EVL_ETC_MAX) begin
				// Span overflow is stored but is not an event.
				log_req = 1'b1;
				log_val = `EVL_ETC_MAX;
				nxt_etc = `EVL_ETC_ZERO;
			end else if (tick) begin
				nxt_etc = etc_ff + 16'h0001;
			end
		end
		if (log_req) begin
			if (!log_full) begin
				nxt_log_wr = 1'b1;
				nxt_log_addr = {ptr_ff[PTR_W-2:0], 1'b0};
				nxt_log_data = log_val;
				nxt_ptr = ptr_ff + PTR_W'(1);
			end else if (log_is_evt) begin
				// Full log: flag it, and on wrap restamp and restart.
				nxt_wrap_flag = 1'b1;
				if (wrap_en_ff) begin
					nxt_start = 1'b1;
					nxt_roll_wr = 1'b1;
					nxt_roll_data = log_val;
					nxt_ptr = '0;
				end
			end
		end
		// The counter only runs while a mission is in progress.
		if (nxt_state != ms_run) begin
			nxt_etc = `EVL_ETC_ZERO;
		end
		// The pin pulls low only in alarm output mode.
		nxt_oe = nxt_alarm && (nxt_dis == `EVL_DIS_ALARM);
	end

	// Read data for the two registers; other offsets read as zero.
	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_rd_stb) begin
			case (reg_addr)
				`EVL_CTRL_ADDR: nxt_rdata = {state_ff != ms_idle,
					wipe_arm_ff, dis_ff, wrap_en_ff, edge_ff, osc_ff};
				`EVL_STAT_ADDR: nxt_rdata = {1'b0, cleared_ff,
					state_ff == ms_run, 1'b0,
					batt_sync.level,
					wrap_flag_ff, 1'b0, alarm_ff};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff <= ms_idle;
			dis_ff <= 2'(`EVL_CTRL_RST >> `EVL_CTRL_DIS_LO_BIT);
			edge_ff <= 2'(`EVL_CTRL_RST >> `EVL_CTRL_EDGE_LO_BIT);
			wrap_en_ff <= 1'(`EVL_CTRL_RST >> `EVL_CTRL_WRAP_BIT);
			osc_ff <= 1'(`EVL_CTRL_RST >> `EVL_CTRL_OSC_BIT);
			wipe_arm_ff <= 1'b0;
			cleared_ff <= `EVL_CLEARED_RST;
			wrap_flag_ff <= 1'b0;
			alarm_ff <= 1'b0;
			etc_ff <= `EVL_ETC_ZERO;
			ptr_ff <= '0;
			rdata_ff <= 8'h00;
			oe_ff <= 1'b0;
			log_wr_ff <= 1'b0;
			log_addr_ff <= '0;
			log_data_ff <= `EVL_ETC_ZERO;
			start_ff <= 1'b0;
			roll_wr_ff <= 1'b0;
			roll_data_ff <= `EVL_ETC_ZERO;
			evcnt_ff <= 1'b0;
			wipe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			dis_ff <= nxt_dis;
			edge_ff <= nxt_edge;
			wrap_en_ff <= nxt_wrap_en;
			osc_ff <= nxt_osc;
			wipe_arm_ff <= nxt_wipe_arm;
			cleared_ff <= nxt_cleared;
			wrap_flag_ff <= nxt_wrap_flag;
			alarm_ff <= nxt_alarm;
			etc_ff <= nxt_etc;
			ptr_ff <= nxt_ptr;
			rdata_ff <= nxt_rdata;
			oe_ff <= nxt_oe;
			log_wr_ff <= nxt_log_wr;
			log_addr_ff <= nxt_log_addr;
			log_data_ff <= nxt_log_data;
			start_ff <= nxt_start;
			roll_wr_ff <= nxt_roll_wr;
			roll_data_ff <= nxt_roll_data;
			evcnt_ff <= nxt_evcnt;
			wipe_ff <= nxt_wipe;
		end
	end

	assign reg_rdata = rdata_ff;
	assign event_pin_o = 1'b0;
	assign event_pin_oe = oe_ff;
	assign osc_run = osc_ff;
	assign log_wr_stb = log_wr_ff;
	assign log_addr = log_addr_ff;
	assign log_data = log_data_ff;
	assign start_stamp_stb = start_ff;
	assign roll_stamp_wr = roll_wr_ff;
	assign roll_stamp_data = roll_data_ff;
	assign event_count_inc = evcnt_ff;
	assign wipe_stb = wipe_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	start_guard_a: assert property ($rose(state_ff == ms_run) |->
		$past(edge_ff) != `EVL_EDGE_NONE &&
		$past(dis_ff) != `EVL_DIS_ALARM && $past(osc_ff))
		else $error("mission started with illegal settings");
	start_clean_a: assert property ($rose(state_ff == ms_run) |->
		$past(cleared_ff) && !cleared_ff)
		else $error("mission started without cleared flag");
	roll_zero_a: assert property ($rose(state_ff == ms_run) |->
		roll_stamp_wr && roll_stamp_data == `EVL_ETC_ZERO)
		else $error("rollover stamp not zeroed at start");
	wipe_done_a: assert property (wipe_stb |-> cleared_ff &&
		!wipe_arm_ff && state_ff == ms_idle && !wrap_flag_ff)
		else $error("wipe left flags wrong");
	no_full_write_a: assert property (
		log_full && !wrap_en_ff |=> !log_wr_stb)
		else $error("log written while full without wrap");
	wrap_hold_a: assert property ($fell(wrap_flag_ff) |-> wipe_stb)
		else $error("wrap flag cleared without wipe");
	alarm_clr_a: assert property ($fell(alarm_ff) |->
		$past(alarm_access) && !$past(alarm_match))
		else $error("alarm flag cleared without access");
	alarm_pin_a: assert property (alarm_match &&
		dis_ff == `EVL_DIS_ALARM && !reg_wr_stb |=> event_pin_oe)
		else $error("alarm did not pull the pin");
	etc_step_a: assert property (state_ff == ms_run &&
		etc_ff != `EVL_ETC_ZERO && etc_ff == $past(etc_ff) + 16'h0001 |->
		$past(tick)) else $error("counter stepped without its tick");
	etc_wrap_a: assert property (etc_ff == `EVL_ETC_MAX |=>
		etc_ff == `EVL_ETC_ZERO && (!event_count_inc || $past(evt)))
		else $error("counter did not restart after max");

endmodule : evl_mission

// ==== evl_mission_tb.sv ====
// Purpose: Self-checking bench for the mission control block.
// Assumes: The host model drives the register port; ticks come from here.
// Notes: The log is cut to four entries so full and wrap come quickly.
`timescale 1ns/10ps
`include "evl_defines.svh"
module evl_mission_tb;
	localparam int LW = 4; // Short log of four entries.
	localparam int PW = 3; // Byte address width for the short log.
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic sec_tick = 1'b0;
	logic min_tick = 1'b0;
	logic hour_tick = 1'b0;
	logic alarm_match = 1'b0;
	logic battery_low_pin = 1'b0;
	logic pin_drv = 1'b0; // Level the outside world puts on the pin.
	logic pin_lvl;
	logic reg_wr_stb, reg_rd_stb, event_pin_o, event_pin_oe, osc_run;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, ctl;
	logic log_wr_stb, start_stamp_stb, roll_stamp_wr;
	logic event_count_inc, wipe_stb;
	logic [PW-1:0] log_addr, last_addr;
	logic [15:0] log_data, roll_stamp_data, last_data, last_roll;
	logic [7:0] bad [3] = '{8'h19, 8'h0b, 8'h1a};
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_log = 0, n_inc = 0, n_wipe = 0, n_stamp = 0, n_roll = 0;
	int b_log, b_inc, b_stamp;

	always #20 clk = ~clk;
	// The block only pulls the pin low; otherwise the bench drives it.
	assign pin_lvl = event_pin_oe ? event_pin_o : pin_drv;

	evl_host_model #(.QUIET_CYC(125)) u_host (
		.clk(clk), .reg_rdata(reg_rdata), .reg_wr_stb(reg_wr_stb),
		.reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
	);
	evl_mission #(.LOG_WORDS(LW), .PTR_W(PW)) u_dut (
		.clk(clk), .srst(srst), .reg_wr_stb(reg_wr_stb),
		.reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sec_tick(sec_tick), .min_tick(min_tick),
		.hour_tick(hour_tick), .alarm_match(alarm_match),
		.battery_low_pin(battery_low_pin), .event_pin_i(pin_lvl),
		.event_pin_o(event_pin_o), .event_pin_oe(event_pin_oe),
		.osc_run(osc_run), .log_wr_stb(log_wr_stb), .log_addr(log_addr),
		.log_data(log_data), .start_stamp_stb(start_stamp_stb),
		.roll_stamp_wr(roll_stamp_wr), .roll_stamp_data(roll_stamp_data),
		.event_count_inc(event_count_inc), .wipe_stb(wipe_stb)
	);

	// Pulses stand one cycle, so they are counted on every edge.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (log_wr_stb === 1'b1) begin
			n_log <= n_log + 1;
			last_addr <= log_addr;
			last_data <= log_data;
		end
		if (roll_stamp_wr === 1'b1) begin
			n_roll <= n_roll + 1;
			last_roll <= roll_stamp_data;
		end
		if (event_count_inc === 1'b1) n_inc <= n_inc + 1;
		if (wipe_stb === 1'b1) n_wipe <= n_wipe + 1;
		if (start_stamp_stb === 1'b1) n_stamp <= n_stamp + 1;
	end

	// The longest scenario holds a tick for 65535 cycles; cut a hang.
	always @(posedge clk) begin
		if (cyc == 90000) begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle

	// One pin change, then time for sync, edge detect and logging.
	task automatic ev();
		@(posedge clk);
		#1;
		pin_drv = ~pin_drv;
		repeat (8) @(posedge clk);
		#1;
	endtask : ev

	// Calendar ticks: k is 0 for seconds, 1 minutes, 2 hours.
	task automatic tick(input int k, input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			{hour_tick, min_tick, sec_tick} = 3'b001 << k;
			@(posedge clk);
			#1;
			{hour_tick, min_tick, sec_tick} = 3'b000;
		end
	endtask : tick

	task automatic pulse_alarm();
		@(posedge clk);
		#1;
		alarm_match = 1'b1;
		@(posedge clk);
		#1;
		alarm_match = 1'b0;
		settle();
	endtask : pulse_alarm

	// Two-write wipe, then the control value for the next mission.
	task automatic wipe_set(input logic [7:0] c);
		u_host.wr(`EVL_CTRL_ADDR, 8'h41);
		u_host.wr(`EVL_STAT_ADDR, 8'h10);
		u_host.wr(`EVL_CTRL_ADDR, c);
	endtask : wipe_set

	task automatic report_and_stop();
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Main sequence of register calls and pin activity.
	initial begin
		repeat (4) @(posedge clk);
		#1;
		srst = 1'b0;
		u_host.rd(`EVL_CTRL_ADDR, d);
		chk(d, `EVL_CTRL_RST);
		u_host.rd(8'h20, d); // An unmapped address reads zero.
		chk(d, 8'h00);
		battery_low_pin = 1'b1;
		settle();
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h08);
		battery_low_pin = 1'b0;
		u_host.wr(`EVL_STAT_ADDR, 8'h20);
		settle();
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h00);
		u_host.wr(`EVL_CTRL_ADDR, 8'h40);
		u_host.wr(`EVL_STAT_ADDR, 8'h10);
		chk(osc_run, 1'b0);
		chk(n_wipe[15:0], 16'h0000);
		u_host.wr(`EVL_CTRL_ADDR, 8'h41);
		u_host.wr(`EVL_STAT_ADDR, 8'h10);
		chk(n_wipe[15:0], 16'h0001);
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h40);
		u_host.rd(`EVL_CTRL_ADDR, d);
		chk(d, 8'h01);
		// Illegal edge code, alarm interval, oscillator off.
		foreach (bad[i]) begin
			u_host.wr(`EVL_CTRL_ADDR, bad[i]);
			u_host.wr(`EVL_STAT_ADDR, 8'h20);
			ev();
			u_host.rd(`EVL_STAT_ADDR, d);
			chk(d, 8'h40);
		end
		chk(n_inc[15:0], 16'h0000);
		// Each interval code counts only its own calendar field.
		for (int m = 1; m < 4; m++) begin
			ctl = {2'b00, m[1:0], 4'hf};
			wipe_set(ctl);
			b_stamp = n_stamp;
			u_host.wr(`EVL_STAT_ADDR, 8'h20);
			settle();
			chk(16'(n_stamp - b_stamp), 16'h0001);
			chk(last_roll, 16'h0000);
			u_host.rd(`EVL_STAT_ADDR, d);
			chk(d, 8'h20);
			u_host.rd(`EVL_CTRL_ADDR, d);
			chk(d, ctl | 8'h80);
			tick(0, 1);
			tick(1, 2);
			tick(2, 3);
			ev();
			chk(last_data, 16'(m));
			chk(16'(last_addr), 16'h0000);
			ev();
			chk(last_data, 16'h0000);
			chk(16'(last_addr), 16'h0002);
			u_host.wr(`EVL_STAT_ADDR, 8'h00);
			u_host.rd(`EVL_STAT_ADDR, d);
			chk(d, 8'h00);
			u_host.rd(`EVL_CTRL_ADDR, d);
			chk(d, ctl);
			b_log = n_log;
			ev();
			chk(16'(n_log - b_log), 16'h0000);
		end
		// Armed for rising edges only.
		pin_drv = 1'b1;
		wipe_set(8'h9d);
		b_stamp = n_stamp;
		ev();
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h40);
		ev();
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h20);
		chk(16'(n_stamp - b_stamp), 16'h0001);
		u_host.wr(`EVL_CTRL_ADDR, 8'h9d);
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h00);
		// Armed for falling edges only; the pin starts low.
		pin_drv = 1'b0;
		wipe_set(8'h9b);
		ev();
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h40);
		ev();
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h20);
		// Full log with wrap enabled.
		wipe_set(8'h1f);
		u_host.wr(`EVL_STAT_ADDR, 8'h20);
		repeat (LW) ev();
		chk(16'(last_addr), 16'h0006);
		b_log = n_log;
		b_stamp = n_stamp;
		tick(0, 3);
		ev();
		chk(16'(n_log - b_log), 16'h0000);
		chk(16'(n_stamp - b_stamp), 16'h0001);
		chk(last_roll, 16'h0003);
		chk(16'(n_roll - n_stamp), 16'h0000);
		ev();
		chk(16'(last_addr), 16'h0000);
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h24);
		// Full log without wrap.
		wipe_set(8'h17);
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h40);
		u_host.wr(`EVL_STAT_ADDR, 8'h20);
		repeat (LW) ev();
		b_log = n_log;
		b_inc = n_inc;
		ev();
		chk(16'(n_log - b_log), 16'h0000);
		chk(16'(n_inc - b_inc), 16'h0001);
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h24);
		// Counter runs to its maximum with no event.
		wipe_set(8'h17);
		u_host.wr(`EVL_STAT_ADDR, 8'h20);
		settle();
		b_log = n_log;
		b_inc = n_inc;
		sec_tick = 1'b1;
		repeat (65535) @(posedge clk);
		#1;
		sec_tick = 1'b0;
		settle();
		chk(16'(n_log - b_log), 16'h0001);
		chk(last_data, `EVL_ETC_MAX);
		chk(16'(n_inc - b_inc), 16'h0000);
		// Alarm with interval 00, then with interval 01.
		u_host.wr(`EVL_CTRL_ADDR, 8'h01);
		pulse_alarm();
		chk(pin_lvl, 1'b0);
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h01);
		u_host.rd(`EVL_ALARM_FIRST, d);
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h00);
		chk(event_pin_oe, 1'b0);
		u_host.wr(`EVL_CTRL_ADDR, 8'h11);
		pulse_alarm();
		chk(event_pin_oe, 1'b0);
		u_host.wr(`EVL_STAT_ADDR, 8'h00);
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h01);
		u_host.wr(`EVL_ALARM_LAST, 8'h00);
		u_host.rd(`EVL_STAT_ADDR, d);
		chk(d, 8'h00);
		report_and_stop();
	end
endmodule : evl_mission_tb

// ==== evl_pkg.sv ====
// Purpose: Types shared by the event log mission control block.
// Assumes: Nothing beyond the defines header.
// Notes: Mission state is idle, armed (waiting for an edge) or running.
package evl_pkg;

	// Mission state; mission_arm is set in armed and running.
	typedef enum {
		ms_idle,
		ms_armed,
		ms_run
	} evl_mission_t;

endpackage : evl_pkg

// ==== evl_sync_edge.sv ====
// Purpose: Two-flop synchroniser with edge detection for one pin.
// Assumes: The pin is asynchronous to clk.
// Notes: Edges are taken from the second and third flops only.
`timescale 1ns/10ps
module evl_sync_edge (
	input wire logic clk,
	input wire logic srst,
	input wire logic pin,
	evl_sync_if.src sync
);
	import evl_pkg::*;

	logic meta_ff; // First stage; read only by the second stage.
	logic stab_ff; // Second stage; the usable level.
	logic prev_ff; // Previous usable level for edge detection.
	logic nxt_meta;
	logic nxt_stab;
	logic nxt_prev;

	// Shift the pin through the stages.
	always_comb begin
		nxt_meta = pin;
		nxt_stab = meta_ff;
		nxt_prev = stab_ff;
	end

	// Registers clear to low, matching the pin pull-down at rest.
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_ff <= 1'b0;
			stab_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			stab_ff <= nxt_stab;
			prev_ff <= nxt_prev;
		end
	end

	assign sync.level = stab_ff;
	assign sync.rise = stab_ff & ~prev_ff;
	assign sync.fall = ~stab_ff & prev_ff;

	// A rise pulse always matches the level change it reports.
	edge_match_a: assert property (@(posedge clk) disable iff (srst)
		sync.rise |-> sync.level && !$past(sync.level))
		else $error("rise pulse without a level change");

endmodule : evl_sync_edge

// ==== evl_sync_if.sv ====
// Purpose: Carries a synchronised pin level and its edges.
// Assumes: Single clock domain on the receiving side.
// Notes: Edges are one-cycle pulses aligned with the level.
`timescale 1ns/10ps
interface evl_sync_if;
	logic level; // Synchronised pin level.
	logic rise; // One-cycle pulse on a low to high change.
	logic fall; // One-cycle pulse on a high to low change.
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : evl_sync_if
